// >>> logic/psc_defines.svh
// Register offsets, field positions, mode codes and widths of the slow-down control block.
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
`define PSC_OFS_CSTEP 8'h00
`define PSC_OFS_CSTEP_STG 8'h04
`define PSC_OFS_SDP 8'h08
`define PSC_OFS_SDP_STG 8'h0c
`define PSC_OFS_AUTO 8'h10
`define PSC_OFS_CCNT 8'h14
`define PSC_OFS_REM 8'h18
`define PSC_OFS_MODE 8'h1c
`define PSC_OFS_MODE_STG 8'h20
`define PSC_OFS_FEED 8'h24
`define PSC_OFS_CTRL 8'h28
`define PSC_OFS_STAT 8'h2c
`define PSC_CTRL_START 0
`define PSC_CTRL_XFER 1
`define PSC_STAT_IRQ 2
`define PSC_MD_SUPPRESS 7
`define PSC_MD_SCURVE 10
`define PSC_MD_SLOWDOWN 13
`define PSC_MODE_W 32
`define PSC_CSTEP_W 31
`define PSC_SDP_W 24
`define PSC_FEED_W 28
`define PSC_SDP_MAX 24'hff_ffff
`define PSC_RESET_VAL 32'h0000_0000
`define PSC_M_TIMER 7'h47
`define PSC_M_PLS_INC 7'h51
`define PSC_M_PLS_ABS1 7'h52
`define PSC_M_PLS_ABS2 7'h53
`define PSC_M_PLS_ZR1 7'h54
`define PSC_M_PLS_ZR2 7'h55
`define PSC_M_SW_INC 7'h56
`define PSC_M_LIN1_CONT 7'h60
`define PSC_M_LIN1_INC 7'h61
`define PSC_M_LIN2_INC 7'h63
`define PSC_M_CIRC_CW 7'h64
`define PSC_M_CIRC_U_CCW 7'h67
`define PSC_M_PLS_LIN1_INC 7'h69
`define PSC_M_PLS_LIN2_INC 7'h6b
`define PSC_M_PLS_CIRC_CW 7'h6c
`define PSC_M_PLS_CIRC_CCW 7'h6d
`define PSC_M_DUMMY_CIRC 7'h6f
`endif

// >>> logic/psc_pkg.sv
// Types shared by the slow-down control block.
`default_nettype none
package psc_pkg;
   typedef enum logic [2:0] {
      PSC_IDLE = 3'b001,
      PSC_RUN = 3'b010,
      PSC_DECEL = 3'b100
   } psc_state_t;
   typedef struct packed {
      logic [1:0] staging;
      logic mode_bad;
      logic irq;
      logic decel;
      logic run;
   } psc_status_t;
endpackage : psc_pkg
`default_nettype wire

// >>> logic/psc_prereg.sv
// Working register with its staging pre-register.
`default_nettype none
module psc_prereg #(
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_work,
   input wire logic wr_stage,
   input wire logic xfer,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] work,
   output logic [W-1:0] stage
);
   logic [W-1:0] work_reg;
   logic [W-1:0] work_next;
   logic [W-1:0] stage_reg;
   logic [W-1:0] stage_next;

   // A direct write to the working register wins over a transfer in the same cycle.
   always_comb begin
      stage_next = stage_reg;
      work_next = work_reg;
      if (wr_stage) begin
         stage_next = wdata;
      end
      if (xfer) begin
         work_next = stage_reg;
      end
      if (wr_work) begin
         work_next = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         work_reg <= '0;
         stage_reg <= '0;
      end else begin
         work_reg <= work_next;
         stage_reg <= stage_next;
      end
   end

   assign work = work_reg;
   assign stage = stage_reg;
endmodule : psc_prereg
`default_nettype wire

// >>> logic/psc_top.sv
// Positioning slow-down control: remaining pulses, slow-down point, step counter, mode.
// How it works
// RL1: Step count register absent on U axis.
// RL2: Step count, slow-down, mode have staging registers.
// RL3: Step count enables automatic slow-down in circles.
// RL4: Auto mode: decelerate when remaining <= calculated value.
// RL5: Auto offset is signed, shifting deceleration start.
// RL6: Offset is 24-bit signed, upper bits sign copies; reads zero-extend it in manual mode.
// RL7: Manual mode: decelerate when remaining <= point.
// RL8: Slow-down point and staging readable and writable.
// RL9: Calculated slow-down value in read-only register.
// RL10: One step counter shared by all axes.
// RL11: Step counter loads at start, counts circle pulses.
// RL12: Step counter never ends interpolation.
// RL13: Remaining recalculated on feed write and start.
// RL14: Incremental start loads remaining with feed amount.
// RL15: Absolute: remaining is distance to chosen counter.
// RL16: Remaining counts down; zero ends positioning.
// RL17: Timer, pulser and switch mode codes decoded.
// RL18: Linear and circular interpolation codes decoded.
// RL19: Pulser interpolation and dummy codes; others flagged.
// RL20: Suppress bit blocks stop flag with staged operation.
// RL21: Mode bit 13 selects automatic or manual point.
// RL22: Counter reads sample without disturbing counting.
`include "psc_defines.svh"
`default_nettype none
module psc_top #(
   parameter bit HAS_CIRC = 1'b1
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic PULSE_IN,
   input wire logic CIRC_PULSE_IN,
   input wire logic STOP_IN,
   input wire logic [27:0] POS_COUNT_ONE,
   input wire logic [27:0] POS_COUNT_TWO,
   input wire logic [23:0] DECEL_DIST,
   input wire logic [1:0] STAGING_STATE,
   input wire logic STOP_IRQ_ENABLE,
   output logic RUNNING,
   output logic DECEL,
   output logic OP_DONE,
   output logic STOP_IRQ_FLAG,
   output logic SCURVE_SELECT
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   function automatic logic is_circ(input logic [6:0] m);
      return (m >= `PSC_M_CIRC_CW && m <= `PSC_M_CIRC_U_CCW) ||
         m == `PSC_M_PLS_CIRC_CW || m == `PSC_M_PLS_CIRC_CCW || m == `PSC_M_DUMMY_CIRC;
   endfunction : is_circ

   function automatic logic is_pos(input logic [6:0] m);
      return m == `PSC_M_TIMER || (m >= `PSC_M_PLS_INC && m <= `PSC_M_SW_INC) ||
         m == `PSC_M_LIN1_INC || m == `PSC_M_LIN2_INC ||
         m == `PSC_M_PLS_LIN1_INC || m == `PSC_M_PLS_LIN2_INC;
   endfunction : is_pos

   function automatic logic is_legal(input logic [6:0] m);
      return m == `PSC_M_TIMER || (m >= `PSC_M_PLS_INC && m <= `PSC_M_SW_INC) ||
         (m >= `PSC_M_LIN1_CONT && m <= `PSC_M_PLS_CIRC_CCW) || m == `PSC_M_DUMMY_CIRC;
   endfunction : is_legal

   function automatic logic [27:0] abs_diff(input logic [27:0] a, input logic [27:0] b);
      logic signed [28:0] d;
      d = $signed({a[27], a}) - $signed({b[27], b});
      if (d < 0) begin
         d = -d;
      end
      return d[27:0];
   endfunction : abs_diff

   // Bus slave: writes complete with no wait, reads take one wait state.
   logic [7:0] addr_reg;
   logic [7:0] addr_next;
   logic wr_pend_reg;
   logic wr_pend_next;
   logic rd_pend_reg;
   logic rd_pend_next;
   logic ready_reg;
   logic ready_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [31:0] rd_mux;
   logic acc;

   assign acc = HSEL && HTRANS[1] && HREADY && HSIZE == 3'b010;

   always_comb begin
      addr_next = acc ? {HADDR[7:2], 2'b00} : addr_reg;
      wr_pend_next = acc && HWRITE;
      rd_pend_next = acc && !HWRITE;
      ready_next = !(acc && !HWRITE);
      rdata_next = rd_pend_reg ? rd_mux : rdata_reg; // RL22
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         addr_reg <= 8'h00;
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         ready_reg <= 1'b1;
         rdata_reg <= `PSC_RESET_VAL;
      end else begin
         addr_reg <= addr_next;
         wr_pend_reg <= wr_pend_next;
         rd_pend_reg <= rd_pend_next;
         ready_reg <= ready_next;
         rdata_reg <= rdata_next;
      end
   end

   logic wr_cstep;
   logic wr_cstep_stg;
   logic wr_sdp;
   logic wr_sdp_stg;
   logic wr_mode;
   logic wr_mode_stg;
   logic wr_feed;
   logic wr_ctrl;
   logic wr_stat;

   assign wr_cstep = wr_pend_reg && addr_reg == `PSC_OFS_CSTEP && HAS_CIRC; // RL1
   assign wr_cstep_stg = wr_pend_reg && addr_reg == `PSC_OFS_CSTEP_STG && HAS_CIRC; // RL1
   assign wr_sdp = wr_pend_reg && addr_reg == `PSC_OFS_SDP; // RL8
   assign wr_sdp_stg = wr_pend_reg && addr_reg == `PSC_OFS_SDP_STG; // RL8
   assign wr_mode = wr_pend_reg && addr_reg == `PSC_OFS_MODE;
   assign wr_mode_stg = wr_pend_reg && addr_reg == `PSC_OFS_MODE_STG;
   assign wr_feed = wr_pend_reg && addr_reg == `PSC_OFS_FEED;
   assign wr_ctrl = wr_pend_reg && addr_reg == `PSC_OFS_CTRL;
   assign wr_stat = wr_pend_reg && addr_reg == `PSC_OFS_STAT;

   // Staged values move to the working registers when an operation ends with a
   // continuation staged, or on software request.
   logic xfer;
   logic done_now;
   logic [30:0] cstep;
   logic [30:0] cstep_stg;
   logic [23:0] sdp;
   logic [23:0] sdp_stg;
   logic [31:0] mode;
   logic [31:0] mode_stg;

   assign xfer = (done_now && STAGING_STATE != 2'b00) || (wr_ctrl && HWDATA[`PSC_CTRL_XFER]);

   // The upper offset bits are not stored, so sign-extension writes vanish.
   psc_prereg #(.W(`PSC_CSTEP_W)) u_cstep ( // RL2
      .clk(CLK),
      .rst_n(RESETN),
      .wr_work(wr_cstep),
      .wr_stage(wr_cstep_stg),
      .xfer(xfer && HAS_CIRC),
      .wdata(HWDATA[30:0]),
      .work(cstep),
      .stage(cstep_stg)
   );
   psc_prereg #(.W(`PSC_SDP_W)) u_sdp ( // RL2 RL6
      .clk(CLK),
      .rst_n(RESETN),
      .wr_work(wr_sdp),
      .wr_stage(wr_sdp_stg),
      .xfer(xfer),
      .wdata(HWDATA[23:0]),
      .work(sdp),
      .stage(sdp_stg)
   );
   psc_prereg #(.W(`PSC_MODE_W)) u_mode ( // RL2
      .clk(CLK),
      .rst_n(RESETN),
      .wr_work(wr_mode),
      .wr_stage(wr_mode_stg),
      .xfer(xfer),
      .wdata(HWDATA),
      .work(mode),
      .stage(mode_stg)
   );

   logic [6:0] mode_code;
   logic manual_sel;
   logic suppress;

   assign mode_code = mode[6:0]; // RL17 RL18 RL19
   assign manual_sel = mode[`PSC_MD_SLOWDOWN]; // RL21
   assign suppress = mode[`PSC_MD_SUPPRESS]; // RL20

   // Motion, remaining count, step counter, calculated point and flags.
   psc_pkg::psc_state_t st_reg;
   psc_pkg::psc_state_t st_next;
   logic [27:0] feed_reg;
   logic [27:0] feed_next;
   logic [27:0] rem_reg;
   logic [27:0] rem_next;
   logic [30:0] ccnt_reg;
   logic [30:0] ccnt_next;
   logic [23:0] auto_reg;
   logic [23:0] auto_next;
   logic done_reg;
   logic irq_reg;
   logic irq_next;
   logic start;
   logic recalc;
   logic stop_cond;
   logic decel_cond;
   logic signed [25:0] auto_sum;
   logic [27:0] feed_mag;

   assign start = wr_ctrl && HWDATA[`PSC_CTRL_START] && st_reg == psc_pkg::PSC_IDLE;
   assign recalc = start || wr_feed; // RL13
   assign stop_cond = STOP_IN || (is_pos(mode_code) && rem_reg == 28'h000_0000); // RL16 RL12
   assign done_now = st_reg != psc_pkg::PSC_IDLE && stop_cond;
   assign auto_sum = $signed({2'b00, DECEL_DIST}) + $signed({{2{sdp[23]}}, sdp}); // RL5

   always_comb begin
      feed_mag = feed_reg[27] ? 28'(-feed_reg) : feed_reg;
      if (manual_sel) begin
         decel_cond = rem_reg <= {4'h0, sdp}; // RL7
      end else if (is_circ(mode_code) && cstep != 31'h0000_0000) begin
         decel_cond = ccnt_reg <= {7'h00, auto_reg}; // RL3
      end else begin
         decel_cond = rem_reg <= {4'h0, auto_reg}; // RL4
      end
   end

   always_comb begin
      st_next = st_reg;
      feed_next = wr_feed ? HWDATA[27:0] : feed_reg;
      rem_next = rem_reg;
      ccnt_next = ccnt_reg;
      irq_next = irq_reg;
      if (auto_sum < 0) begin
         auto_next = 24'h00_0000;
      end else if (auto_sum > $signed({2'b00, `PSC_SDP_MAX})) begin
         auto_next = `PSC_SDP_MAX;
      end else begin
         auto_next = auto_sum[23:0]; // RL9
      end
      if (st_reg != psc_pkg::PSC_IDLE && PULSE_IN && rem_reg != 28'h000_0000) begin
         rem_next = rem_reg - 28'h000_0001; // RL16
      end
      if (recalc) begin
         if (mode_code == `PSC_M_PLS_ABS1 || mode_code == `PSC_M_PLS_ZR1) begin
            rem_next = abs_diff(feed_next, POS_COUNT_ONE); // RL15
         end else if (mode_code == `PSC_M_PLS_ABS2 || mode_code == `PSC_M_PLS_ZR2) begin
            rem_next = abs_diff(feed_next, POS_COUNT_TWO); // RL15
         end else begin
            rem_next = wr_feed ? (HWDATA[27] ? 28'(-HWDATA[27:0]) : HWDATA[27:0]) :
               feed_mag; // RL14
         end
      end
      if (HAS_CIRC && st_reg != psc_pkg::PSC_IDLE && CIRC_PULSE_IN &&
          ccnt_reg != 31'h0000_0000) begin
         ccnt_next = ccnt_reg - 31'h0000_0001; // RL11
      end
      if (start && is_circ(mode_code)) begin
         ccnt_next = cstep; // RL11
      end
      unique case (st_reg)
         psc_pkg::PSC_IDLE: begin
            if (start) begin
               st_next = psc_pkg::PSC_RUN;
            end
         end
         psc_pkg::PSC_RUN: begin
            if (stop_cond) begin
               st_next = psc_pkg::PSC_IDLE;
            end else if (decel_cond) begin
               st_next = psc_pkg::PSC_DECEL;
            end
         end
         psc_pkg::PSC_DECEL: begin
            if (stop_cond) begin
               st_next = psc_pkg::PSC_IDLE;
            end
         end
         default: begin
            st_next = psc_pkg::PSC_IDLE;
         end
      endcase
      // Software clears by writing one; a stop in the same cycle keeps the flag set.
      if (wr_stat && HWDATA[`PSC_STAT_IRQ]) begin
         irq_next = 1'b0;
      end
      if (done_now && STOP_IRQ_ENABLE && !(suppress && STAGING_STATE[1])) begin
         irq_next = 1'b1; // RL20
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         st_reg <= psc_pkg::PSC_IDLE;
         feed_reg <= 28'h000_0000;
         rem_reg <= 28'h000_0000;
         ccnt_reg <= 31'h0000_0000;
         auto_reg <= 24'h00_0000;
         done_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         feed_reg <= feed_next;
         rem_reg <= rem_next;
         ccnt_reg <= ccnt_next;
         auto_reg <= auto_next;
         done_reg <= done_now;
         irq_reg <= irq_next;
      end
   end

   psc_pkg::psc_status_t status;

   always_comb begin
      status.staging = STAGING_STATE;
      status.mode_bad = !is_legal(mode_code); // RL19
      status.irq = irq_reg;
      status.decel = st_reg == psc_pkg::PSC_DECEL;
      status.run = st_reg != psc_pkg::PSC_IDLE;
   end

   // The offset reads sign-extended in automatic mode and zero-extended in manual mode.
   always_comb begin
      rd_mux = `PSC_RESET_VAL;
      unique case (addr_reg)
         `PSC_OFS_CSTEP: rd_mux = HAS_CIRC ? {1'b0, cstep} : `PSC_RESET_VAL; // RL1
         `PSC_OFS_CSTEP_STG: rd_mux = HAS_CIRC ? {1'b0, cstep_stg} : `PSC_RESET_VAL;
         `PSC_OFS_SDP: rd_mux = {{8{sdp[23] && !manual_sel}}, sdp}; // RL6 RL8
         `PSC_OFS_SDP_STG: rd_mux = {{8{sdp_stg[23] && !manual_sel}}, sdp_stg}; // RL8
         `PSC_OFS_AUTO: rd_mux = {8'h00, auto_reg}; // RL9
         `PSC_OFS_CCNT: rd_mux = {1'b0, ccnt_reg}; // RL10 RL22
         `PSC_OFS_REM: rd_mux = {4'h0, rem_reg}; // RL22
         `PSC_OFS_MODE: rd_mux = mode;
         `PSC_OFS_MODE_STG: rd_mux = mode_stg;
         `PSC_OFS_FEED: rd_mux = {{4{feed_reg[27]}}, feed_reg};
         `PSC_OFS_STAT: rd_mux = {26'h000_0000, status};
         default: rd_mux = `PSC_RESET_VAL;
      endcase
   end

   assign HRDATA = rdata_reg;
   assign HREADYOUT = ready_reg;
   assign HRESP = 1'b0;
   assign RUNNING = status.run;
   assign DECEL = status.decel;
   assign OP_DONE = done_reg;
   assign STOP_IRQ_FLAG = irq_reg;
   assign SCURVE_SELECT = mode[`PSC_MD_SCURVE];

   read_wait_a: assert property (rd_pend_reg |-> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait state wrong");
   decel_entry_a: assert property ( // RL4
      st_reg == psc_pkg::PSC_RUN && !stop_cond && decel_cond |=> DECEL)
      else $error("deceleration not started");
   manual_point_a: assert property ( // RL7
      st_reg == psc_pkg::PSC_RUN && !stop_cond && manual_sel && rem_reg > {4'h0, sdp}
      |=> !DECEL)
      else $error("manual deceleration too early");
   pos_done_a: assert property ( // RL16
      RUNNING && is_pos(mode_code) && rem_reg == 28'h000_0000 |=> OP_DONE && !RUNNING)
      else $error("positioning did not complete at zero");
   rem_count_a: assert property ( // RL16
      RUNNING && PULSE_IN && rem_reg != 28'h000_0000 && !recalc
      |=> rem_reg == $past(rem_reg) - 28'h000_0001)
      else $error("remaining count did not step");
   circ_load_a: assert property ( // RL11
      start && is_circ(mode_code) && HAS_CIRC |=> ccnt_reg == $past(cstep))
      else $error("step counter not loaded");
   circ_no_end_a: assert property ( // RL12
      RUNNING && !STOP_IN && !is_pos(mode_code) && ccnt_reg == 31'h0000_0000 |=> RUNNING)
      else $error("step counter ended interpolation");
   irq_suppress_a: assert property ( // RL20
      done_now && suppress && STAGING_STATE[1] && !irq_reg |=> !STOP_IRQ_FLAG)
      else $error("stop flag not suppressed");
   irq_set_a: assert property ( // RL20
      done_now && STOP_IRQ_ENABLE && !suppress |=> STOP_IRQ_FLAG)
      else $error("stop flag not set");
   sign_ext_a: assert property ( // RL6
      rd_pend_reg && addr_reg == `PSC_OFS_SDP && !manual_sel
      |=> HRDATA[31:24] == {8{HRDATA[23]}})
      else $error("offset not sign extended");
   no_uaxis_a: assert property ( // RL1
      rd_pend_reg && addr_reg == `PSC_OFS_CSTEP && !HAS_CIRC |=> HRDATA == `PSC_RESET_VAL)
      else $error("step count present on U axis");
endmodule : psc_top
`default_nettype wire

// >>> tb/positioning_slowdown_control_test.sv
// Self-checking bench of the slow-down control block.
`include "psc_defines.svh"
`default_nettype none
module positioning_slowdown_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, rd;
   logic hready, pulse, cpulse, running, decel, op_done, irq_flag, lg;
   logic hresp, scurve;
   logic stop_in = 1'b0;
   logic circ_en = 1'b0;
   logic irq_en = 1'b0;
   logic [1:0] stg = 2'b00;
   logic [7:0] gap = 8'h28;
   logic [23:0] decel_dist = 24'h00_0000;
   logic [27:0] pos_one = 28'h000_0003;
   logic [27:0] pos_two = 28'h000_0019;
   logic [15:0] n_pulse, base;
   int n_mismatch = 0;
   int comparisons = 0;

   psc_top psc_top_inst (
      .CLK(clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .PULSE_IN(pulse), .CIRC_PULSE_IN(cpulse),
      .STOP_IN(stop_in), .POS_COUNT_ONE(pos_one), .POS_COUNT_TWO(pos_two),
      .DECEL_DIST(decel_dist), .STAGING_STATE(stg), .STOP_IRQ_ENABLE(irq_en),
      .RUNNING(running), .DECEL(decel), .OP_DONE(op_done), .STOP_IRQ_FLAG(irq_flag),
      .SCURVE_SELECT(scurve)
   );

   psc_motor_model psc_motor_model_inst (
      .clk(clk), .rst_n(resetn), .run(running), .circ_en(circ_en), .gap(gap),
      .pulse(pulse), .circ_pulse(cpulse), .n_pulse(n_pulse)
   );

   initial begin
      forever #2 clk = ~clk;
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One single-word transfer; the address phase is held until the slave is ready.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      if (w) hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rchk

   // Positioning move: pulses seen when deceleration starts and when the move ends.
   task automatic run(input logic [31:0] feed, input logic [15:0] npre);
      wr(`PSC_OFS_FEED, feed);
      base = n_pulse;
      wr(`PSC_OFS_CTRL, 32'h0000_0001);
      while (decel !== 1'b1) @(posedge clk);
      chk({16'h0000, n_pulse - base}, {16'h0000, npre});
      while (op_done !== 1'b1) @(posedge clk);
      chk({16'h0000, n_pulse - base}, feed);
      // The done pulse must stand for exactly one cycle.
      @(posedge clk);
      chk({31'h0000_0000, op_done}, 32'h0000_0000);
      rchk(`PSC_OFS_REM, 32'h0000_0000);
   endtask : run

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      wrap_up;
   end

   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (logic [7:0] a = 8'h00; a < 8'h2c; a += 8'h04)
         rchk(a, 32'h0000_0000);
      wr(8'h30, 32'hffff_ffff);
      rchk(8'h30, 32'h0000_0000);
      wr(`PSC_OFS_CSTEP, 32'hffff_ffff);
      rchk(`PSC_OFS_CSTEP, 32'h7fff_ffff);
      $display("registers done");
      for (logic [7:0] c = 8'h40; c < 8'h70; c++) begin
         lg = c == 8'h47 || (c > 8'h50 && c < 8'h57) || (c > 8'h5f && c < 8'h6e) || c == 8'h6f;
         wr(`PSC_OFS_MODE, {24'h00_0000, c});
         rchk(`PSC_OFS_STAT, {28'h000_0000, !lg, 3'b000});
      end
      $display("mode codes done");
      wr(`PSC_OFS_MODE, 32'h0000_0051);
      wr(`PSC_OFS_SDP, 32'h0080_0000);
      rchk(`PSC_OFS_SDP, 32'hff80_0000);
      wr(`PSC_OFS_SDP, 32'hff7f_ffff);
      rchk(`PSC_OFS_SDP, 32'h007f_ffff);
      wr(`PSC_OFS_MODE, 32'h0000_2051);
      wr(`PSC_OFS_MODE_STG, 32'h0000_2051);
      wr(`PSC_OFS_SDP_STG, 32'h0080_0004);
      rchk(`PSC_OFS_SDP_STG, 32'h0080_0004);
      rchk(`PSC_OFS_SDP, 32'h007f_ffff);
      wr(`PSC_OFS_CTRL, 32'h0000_0002);
      rchk(`PSC_OFS_SDP, 32'h0080_0004);
      rchk(`PSC_OFS_MODE, 32'h0000_2051);
      chk({31'h0000_0000, scurve}, 32'h0000_0000);
      wr(`PSC_OFS_MODE, 32'h0000_2451);
      @(posedge clk);
      chk({31'h0000_0000, scurve}, 32'h0000_0001);
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
      wr(`PSC_OFS_MODE, 32'h0000_2051);
      $display("slow-down point done");
      wr(`PSC_OFS_FEED, 32'h0fff_fffb);
      rchk(`PSC_OFS_REM, 32'h0000_0005);
      wr(`PSC_OFS_MODE, 32'h0000_2052);
      wr(`PSC_OFS_FEED, 32'h0000_000a);
      rchk(`PSC_OFS_REM, 32'h0000_0007);
      wr(`PSC_OFS_MODE, 32'h0000_2053);
      wr(`PSC_OFS_FEED, 32'h0000_000a);
      rchk(`PSC_OFS_REM, 32'h0000_000f);
      $display("remaining done");
      wr(`PSC_OFS_MODE, 32'h0000_2051);
      wr(`PSC_OFS_SDP, 32'h0000_0004);
      run(32'h0000_000a, 16'h0006);
      $display("manual run done");
      wr(`PSC_OFS_MODE, 32'h0000_0051);
      decel_dist <= 24'h00_0006;
      wr(`PSC_OFS_SDP, 32'h00ff_fffd);
      rchk(`PSC_OFS_AUTO, 32'h0000_0003);
      wr(`PSC_OFS_SDP, 32'h0000_0002);
      rchk(`PSC_OFS_AUTO, 32'h0000_0008);
      run(32'h0000_000c, 16'h0004);
      $display("auto run done");
      wr(`PSC_OFS_CSTEP, 32'h0000_0005);
      wr(`PSC_OFS_MODE, 32'h0000_0064);
      wr(`PSC_OFS_SDP, 32'h0000_0000);
      decel_dist <= 24'h00_0002;
      wr(`PSC_OFS_FEED, 32'h0000_1000);
      circ_en <= 1'b1;
      base = n_pulse;
      wr(`PSC_OFS_CTRL, 32'h0000_0001);
      rchk(`PSC_OFS_CCNT, 32'h0000_0005);
      while (n_pulse !== base + 16'h0002) @(posedge clk);
      repeat (2) @(posedge clk);
      rchk(`PSC_OFS_CCNT, 32'h0000_0003);
      chk({31'h0000_0000, decel}, 32'h0000_0000);
      gap <= 8'h03;
      while (n_pulse !== base + 16'h0007) @(posedge clk);
      repeat (2) @(posedge clk);
      chk({31'h0000_0000, decel}, 32'h0000_0001);
      chk({31'h0000_0000, running}, 32'h0000_0001);
      rchk(`PSC_OFS_CCNT, 32'h0000_0000);
      stop_in <= 1'b1;
      @(posedge clk);
      stop_in <= 1'b0;
      circ_en <= 1'b0;
      gap <= 8'h28;
      while (op_done !== 1'b1) @(posedge clk);
      // With the stop interrupt disabled, a stop leaves the flag clear.
      chk({31'h0000_0000, irq_flag}, 32'h0000_0000);
      $display("circular done");
      irq_en <= 1'b1;
      stg <= 2'b10;
      wr(`PSC_OFS_MODE, 32'h0000_20d1);
      wr(`PSC_OFS_MODE_STG, 32'h0000_20d1);
      wr(`PSC_OFS_SDP, 32'h0000_0001);
      wr(`PSC_OFS_SDP_STG, 32'h0000_0001);
      run(32'h0000_0003, 16'h0002);
      repeat (2) @(posedge clk);
      chk({31'h0000_0000, irq_flag}, 32'h0000_0000);
      wr(`PSC_OFS_MODE, 32'h0000_2051);
      wr(`PSC_OFS_MODE_STG, 32'h0000_2051);
      run(32'h0000_0003, 16'h0002);
      repeat (2) @(posedge clk);
      chk({31'h0000_0000, irq_flag}, 32'h0000_0001);
      wr(`PSC_OFS_STAT, 32'h0000_0004);
      repeat (2) @(posedge clk);
      chk({31'h0000_0000, irq_flag}, 32'h0000_0000);
      $display("stop flag done");
      wrap_up;
   end
endmodule : positioning_slowdown_control_test
`default_nettype wire

// >>> tb/psc_motor_model.sv
// Behavioural motor driver that answers the axis with output pulses.
`default_nettype none
module psc_motor_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic circ_en,
   input wire logic [7:0] gap,
   output logic pulse,
   output logic circ_pulse,
   output logic [15:0] n_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_reg;
   logic fire;
   // A greater-or-equal test lets the bench shorten the gap mid-run without a wrap-around stall.
   assign fire = run && (cnt_reg >= gap);
   // Pulses leave the driver only while the axis runs; the gap sets how slowly it answers.
   always_ff @(posedge clk) begin
      if (!rst_n || !run) begin
         cnt_reg <= 8'h00;
         pulse <= 1'b0;
         circ_pulse <= 1'b0;
      end else begin
         cnt_reg <= fire ? 8'h00 : cnt_reg + 8'h01;
         pulse <= fire;
         circ_pulse <= fire && circ_en;
      end
      if (!rst_n) begin
         n_pulse <= 16'h0000;
      end else if (fire) begin
         n_pulse <= n_pulse + 16'h0001;
      end
   end
endmodule : psc_motor_model
`default_nettype wire
